// [mlm_defs.svh]
// register offsets, field positions, reset values and timing counts of the monitor loop
`ifndef MLM_DEFS_SVH
`define MLM_DEFS_SVH

// register offsets
`define MLM_VALUE_BASE      8'h20
`define MLM_LIMIT_BASE      8'h30
`define MLM_CONFIG_ADDR     8'h40
`define MLM_STATUS1_ADDR    8'h41
`define MLM_STATUS2_ADDR    8'h42

// field positions
`define MLM_CFG_START_BIT   0
`define MLM_ST2_FAULT_BIT   6

// reset values
`define MLM_CONFIG_RESET    8'h00
`define MLM_STATUS_RESET    8'h00
`define MLM_VALUE_RESET     8'h00
`define MLM_UNMAPPED_DATA   8'h00

// timing
`define MLM_CLK_NS          50
`define MLM_SLOT_NS         11600000
`define MLM_REMOTE_NS       34800000
`define MLM_SLOT_CYCLES     (`MLM_SLOT_NS / `MLM_CLK_NS)
`define MLM_REMOTE_CYCLES   (`MLM_REMOTE_NS / `MLM_CLK_NS)
`define MLM_AVG_COUNT       16

`endif

// [mlm_pkg.sv]
// types shared by the monitor loop modules
package mlm_pkg;

    typedef enum logic [3:0] {
        SEQ_IDLE,
        SEQ_CONV,
        SEQ_WAIT,
        SEQ_FETCH_HI,
        SEQ_FETCH_LO,
        SEQ_COMPARE,
        SEQ_COMMIT,
        SEQ_SLOT
    } mlm_seq_t;

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_MEM,
        HOST_DONE
    } mlm_host_t;

endpackage : mlm_pkg

// [mlm_regmem.sv]
// limit memory: one write port, two read ports with registered data
`timescale 1ns/1ps
`default_nettype none

module mlm_regmem #(
    parameter int DW    = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock
    input  wire logic          ref_clk,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read port a
    input  wire logic [AW-1:0] rd_addr_a,
    output logic      [DW-1:0] rd_data_a,
    // read port b
    input  wire logic [AW-1:0] rd_addr_b,
    output logic      [DW-1:0] rd_data_b
);

    // no reset on the array: limits are undefined until software writes them
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end

endmodule : mlm_regmem

`default_nettype wire

// [mlm_link_port.sv]
// serial-link register port: link-clock capture and toggle handshake into the core clock
`timescale 1ns/1ps
`default_nettype none

module mlm_link_port (
    // clocks and reset
    input  wire logic       ref_clk,
    input  wire logic       link_clk,
    input  wire logic       rst_n,
    // link side, on link_clk
    input  wire logic       link_req,
    input  wire logic       link_we,
    input  wire logic [7:0] link_addr,
    input  wire logic [7:0] link_wdata,
    output logic      [7:0] link_rdata,
    output logic            link_ack,
    output logic            link_busy,
    // core side, on ref_clk
    output logic            core_req,
    output logic            core_we,
    output logic      [7:0] core_addr,
    output logic      [7:0] core_wdata,
    input  wire logic       core_done,
    input  wire logic [7:0] core_rdata
);

    // link domain
    logic       req_tgl;
    logic       l_we;
    logic [7:0] l_addr;
    logic [7:0] l_wdata;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_s3;
    // core domain
    logic       ack_tgl;
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;

    wire take_req  = link_req & ~link_busy;
    wire ack_edge  = ack_s2 ^ ack_s3;
    wire req_edge  = req_s2 ^ req_s3;

    // address and data stay still while busy, so the core samples them safely
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_tgl    <= 1'b0;
            l_we       <= 1'b0;
            l_addr     <= 8'h00;
            l_wdata    <= 8'h00;
            link_busy  <= 1'b0;
            link_ack   <= 1'b0;
            link_rdata <= 8'h00;
            ack_s1     <= 1'b0;
            ack_s2     <= 1'b0;
            ack_s3     <= 1'b0;
        end else begin
            ack_s1   <= ack_tgl;
            ack_s2   <= ack_s1;
            ack_s3   <= ack_s2;
            link_ack <= ack_edge;
            if (take_req) begin
                req_tgl   <= ~req_tgl;
                l_we      <= link_we;
                l_addr    <= link_addr;
                l_wdata   <= link_wdata;
                link_busy <= 1'b1;
            end else if (ack_edge) begin
                link_busy  <= 1'b0;
                link_rdata <= core_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1     <= 1'b0;
            req_s2     <= 1'b0;
            req_s3     <= 1'b0;
            ack_tgl    <= 1'b0;
            core_req   <= 1'b0;
            core_we    <= 1'b0;
            core_addr  <= 8'h00;
            core_wdata <= 8'h00;
        end else begin
            req_s1   <= req_tgl;
            req_s2   <= req_s1;
            req_s3   <= req_s2;
            core_req <= req_edge;
            if (req_edge) begin
                core_we    <= l_we;
                core_addr  <= l_addr;
                core_wdata <= l_wdata;
            end
            if (core_done) begin
                ack_tgl <= ~ack_tgl;
            end
        end
    end

endmodule : mlm_link_port

`default_nettype wire

// [mlm_monitor.sv]
// monitor loop: round-robin sequencer, averaging, limit compare, status and value registers
`include "mlm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mlm_monitor #(
    parameter int NUM_CH        = 8,
    parameter int LOCAL_CH      = 6,
    parameter int REMOTE_CH     = 7,
    parameter int CNT_W         = 20,
    parameter int SLOT_CYCLES   = `MLM_SLOT_CYCLES,
    parameter int REMOTE_CYCLES = `MLM_REMOTE_CYCLES
) (
    // clocks and reset
    input  wire logic       ref_clk,
    input  wire logic       link_clk,
    input  wire logic       rst_n,
    // register access from the serial link, on link_clk
    input  wire logic       link_req,
    input  wire logic       link_we,
    input  wire logic [7:0] link_addr,
    input  wire logic [7:0] link_wdata,
    output logic      [7:0] link_rdata,
    output logic            link_ack,
    output logic            link_busy,
    // converter
    output logic            adc_start,
    output logic      [2:0] adc_chan,
    input  wire logic       adc_done,
    input  wire logic [7:0] adc_data,
    // remote diode fault comparators, asynchronous
    input  wire logic       anode_gnd_short,
    input  wire logic       anode_supply_short,
    input  wire logic       diode_short,
    input  wire logic       diode_open,
    // event and loop-running outputs
    output logic            limit_event,
    output logic            loop_running
);

    // core-side register request
    logic       core_req;
    logic       core_we;
    logic [7:0] core_addr;
    logic [7:0] core_wdata;
    logic       core_done;
    logic [7:0] core_rdata;

    mlm_link_port u_link (
        .ref_clk    (ref_clk),
        .link_clk   (link_clk),
        .rst_n      (rst_n),
        .link_req   (link_req),
        .link_we    (link_we),
        .link_addr  (link_addr),
        .link_wdata (link_wdata),
        .link_rdata (link_rdata),
        .link_ack   (link_ack),
        .link_busy  (link_busy),
        .core_req   (core_req),
        .core_we    (core_we),
        .core_addr  (core_addr),
        .core_wdata (core_wdata),
        .core_done  (core_done),
        .core_rdata (core_rdata)
    );

    // register state
    logic [7:0]        config_reg;
    logic [7:0]        status1;
    logic [7:0]        status2;
    logic [7:0]        value_reg [NUM_CH];
    mlm_pkg::mlm_seq_t  seq_state;
    mlm_pkg::mlm_host_t host_state;

    // sequencer state
    logic [2:0]        chan;
    logic [CNT_W-1:0]  slot_cnt;
    logic [3:0]        avg_cnt;
    logic [11:0]       avg_acc;
    logic [7:0]        result;
    logic [7:0]        lim_hi;
    logic              out_of_limit;
    logic              fault_seen;

    // fault synchronisers: stage one feeds stage two only
    logic [3:0]        fault_s1;
    logic [3:0]        fault_s2;

    // limit memory
    logic [3:0]        lim_rd_addr;
    logic [7:0]        lim_seq_data;
    logic [7:0]        host_mem_data;

    // host decode
    wire        is_config   = core_addr == `MLM_CONFIG_ADDR;
    wire        is_status1  = core_addr == `MLM_STATUS1_ADDR;
    wire        is_status2  = core_addr == `MLM_STATUS2_ADDR;
    wire        is_value    = core_addr[7:3] == 5'(`MLM_VALUE_BASE >> 3);
    wire        is_limit    = core_addr[7:4] == 4'(`MLM_LIMIT_BASE >> 4);
    wire        host_rd     = core_req & ~core_we;
    wire        host_wr     = core_req & core_we;
    wire        limit_wr    = host_wr & is_limit;
    wire        start_bit   = config_reg[`MLM_CFG_START_BIT];
    wire [7:0]  value_sel   = value_reg[core_addr[2:0]];
    // reads have no side effects on any flag
    wire [7:0]  direct_rdata = is_config  ? config_reg :
                               is_status1 ? status1    :
                               is_status2 ? status2    :
                               is_value   ? value_sel  :
                               `MLM_UNMAPPED_DATA;

    // sequencer helpers
    wire        is_remote   = chan == 3'(REMOTE_CH);
    wire        is_temp     = is_remote | (chan == 3'(LOCAL_CH));
    wire [11:0] acc_next    = avg_acc + {{4{adc_data[7]}}, adc_data};
    wire        last_avg    = avg_cnt == 4'(`MLM_AVG_COUNT - 1);
    wire        any_fault   = |fault_s2;
    wire        slot_done   = slot_cnt == '0;
    wire        last_chan   = chan == 3'(NUM_CH - 1);
    // temperatures compare signed, voltages unsigned
    wire        above_hi    = is_temp ? ($signed(result) > $signed(lim_hi))
                                      : (result > lim_hi);
    wire        below_lo    = is_temp ? ($signed(result) < $signed(lim_seq_data))
                                      : (result < lim_seq_data);
    // a commit waits while a host byte read is in flight
    wire        commit_ok   = (host_state == mlm_pkg::HOST_IDLE) & ~core_req;
    wire [CNT_W-1:0] slot_load_rem = CNT_W'(REMOTE_CYCLES - 1);
    wire [CNT_W-1:0] slot_load_std = CNT_W'(SLOT_CYCLES - 1);

    mlm_regmem #(
        .DW    (8),
        .DEPTH (2 * NUM_CH),
        .AW    (4)
    ) u_limits (
        .ref_clk   (ref_clk),
        .wr_en     (limit_wr),
        .wr_addr   (core_addr[3:0]),
        .wr_data   (core_wdata),
        .rd_addr_a (core_addr[3:0]),
        .rd_data_a (host_mem_data),
        .rd_addr_b (lim_rd_addr),
        .rd_data_b (lim_seq_data)
    );

    // fault comparators are asynchronous to ref_clk
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_s1 <= 4'h0;
            fault_s2 <= 4'h0;
        end else begin
            fault_s1 <= {anode_gnd_short, anode_supply_short, diode_short, diode_open};
            fault_s2 <= fault_s1;
        end
    end

    // host register access
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_state <= mlm_pkg::HOST_IDLE;
            core_done  <= 1'b0;
            core_rdata <= 8'h00;
            config_reg <= `MLM_CONFIG_RESET;
        end else begin
            core_done <= 1'b0;
            case (host_state)
                mlm_pkg::HOST_IDLE: begin
                    if (host_wr) begin
                        if (is_config) begin
                            config_reg <= core_wdata;
                        end
                        core_done <= 1'b1;
                    end else if (host_rd && is_limit) begin
                        host_state <= mlm_pkg::HOST_MEM;
                    end else if (host_rd) begin
                        core_rdata <= direct_rdata;
                        core_done  <= 1'b1;
                    end
                end
                mlm_pkg::HOST_MEM: begin
                    host_state <= mlm_pkg::HOST_DONE;
                end
                mlm_pkg::HOST_DONE: begin
                    core_rdata <= host_mem_data;
                    core_done  <= 1'b1;
                    host_state <= mlm_pkg::HOST_IDLE;
                end
                default: begin
                    host_state <= mlm_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    // round-robin sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_state    <= mlm_pkg::SEQ_IDLE;
            chan         <= 3'h0;
            slot_cnt     <= '0;
            avg_cnt      <= 4'h0;
            avg_acc      <= 12'h000;
            result       <= 8'h00;
            lim_hi       <= 8'h00;
            lim_rd_addr  <= 4'h0;
            out_of_limit <= 1'b0;
            fault_seen   <= 1'b0;
            adc_start    <= 1'b0;
            adc_chan     <= 3'h0;
            loop_running <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            if (seq_state != mlm_pkg::SEQ_SLOT && slot_cnt != '0) begin
                slot_cnt <= slot_cnt - 1'b1;
            end
            if (!start_bit) begin
                // stopping abandons the conversion in progress; its result is never stored
                seq_state    <= mlm_pkg::SEQ_IDLE;
                loop_running <= 1'b0;
            end else begin
                case (seq_state)
                    mlm_pkg::SEQ_IDLE: begin
                        chan         <= 3'h0;
                        avg_cnt      <= 4'h0;
                        avg_acc      <= 12'h000;
                        fault_seen   <= 1'b0;
                        slot_cnt     <= slot_load_std;
                        loop_running <= 1'b1;
                        seq_state    <= mlm_pkg::SEQ_CONV;
                    end
                    mlm_pkg::SEQ_CONV: begin
                        adc_start <= 1'b1;
                        adc_chan  <= chan;
                        seq_state <= mlm_pkg::SEQ_WAIT;
                    end
                    mlm_pkg::SEQ_WAIT: begin
                        if (is_remote && any_fault) begin
                            fault_seen <= 1'b1;
                        end
                        if (adc_done) begin
                            if (is_remote) begin
                                avg_acc <= acc_next;
                                avg_cnt <= avg_cnt + 1'b1;
                                if (last_avg) begin
                                    // sum of sixteen, arithmetic divide by sixteen
                                    result    <= acc_next[11:4];
                                    seq_state <= mlm_pkg::SEQ_FETCH_HI;
                                end else begin
                                    seq_state <= mlm_pkg::SEQ_CONV;
                                end
                            end else begin
                                result    <= adc_data;
                                seq_state <= mlm_pkg::SEQ_FETCH_HI;
                            end
                            lim_rd_addr <= {chan, 1'b0};
                        end
                    end
                    mlm_pkg::SEQ_FETCH_HI: begin
                        lim_rd_addr <= {chan, 1'b1};
                        seq_state   <= mlm_pkg::SEQ_FETCH_LO;
                    end
                    mlm_pkg::SEQ_FETCH_LO: begin
                        lim_hi    <= lim_seq_data;
                        seq_state <= mlm_pkg::SEQ_COMPARE;
                    end
                    mlm_pkg::SEQ_COMPARE: begin
                        out_of_limit <= above_hi | below_lo;
                        seq_state    <= mlm_pkg::SEQ_COMMIT;
                    end
                    mlm_pkg::SEQ_COMMIT: begin
                        if (commit_ok) begin
                            seq_state <= mlm_pkg::SEQ_SLOT;
                        end
                    end
                    mlm_pkg::SEQ_SLOT: begin
                        if (slot_done) begin
                            // each slot holds the channel until its nominal time ends
                            avg_cnt    <= 4'h0;
                            avg_acc    <= 12'h000;
                            fault_seen <= 1'b0;
                            chan       <= last_chan ? 3'h0 : chan + 1'b1;
                            slot_cnt   <= (chan == 3'(REMOTE_CH - 1)) ? slot_load_rem
                                          : slot_load_std;
                            seq_state  <= mlm_pkg::SEQ_CONV;
                        end else begin
                            slot_cnt <= slot_cnt - 1'b1;
                        end
                    end
                    default: begin
                        seq_state <= mlm_pkg::SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    // value, status and event update in one cycle
    wire commit_now = start_bit & (seq_state == mlm_pkg::SEQ_COMMIT) & commit_ok;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status1     <= `MLM_STATUS_RESET;
            status2     <= `MLM_STATUS_RESET;
            limit_event <= 1'b0;
        end else begin
            limit_event <= commit_now & out_of_limit;
            if (commit_now) begin
                status1[chan] <= out_of_limit;
                if (is_remote) begin
                    status2[`MLM_ST2_FAULT_BIT] <= fault_seen | any_fault;
                end
            end
        end
    end

    // value registers, one per channel
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_value
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    value_reg[gi] <= `MLM_VALUE_RESET;
                end else if (commit_now && chan == 3'(gi)) begin
                    value_reg[gi] <= result;
                end
            end
        end
    endgenerate

endmodule : mlm_monitor

`default_nettype wire

// [mlm_monitor_props.sv]
// assertions on the monitor loop ports
`timescale 1ns/1ps
`default_nettype none
module mlm_monitor_props (
    // clocks and reset
    input wire logic       ref_clk,
    input wire logic       link_clk,
    input wire logic       rst_n,
    // link
    input wire logic       link_req,
    input wire logic       link_ack,
    input wire logic       link_busy,
    // converter and status
    input wire logic       adc_start,
    input wire logic [2:0] adc_chan,
    input wire logic       limit_event,
    input wire logic       loop_running
);
    logic [2:0] last_chan;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) last_chan <= 3'h0;
        else if (adc_start) last_chan <= adc_chan;
    end
    // any request seen with busy low is taken at that edge, the ack edge included
    sequence s_take; link_req && !link_busy; endsequence
    sequence s_answer; ##[3:40] link_ack; endsequence
    property p_busy_after_take; @(posedge link_clk) disable iff (!rst_n) s_take |=> link_busy; endproperty
    property p_ack_bound; @(posedge link_clk) disable iff (!rst_n) $rose(link_busy) |-> s_answer; endproperty
    property p_ack_pulse; @(posedge link_clk) disable iff (!rst_n) link_ack |=> !link_ack; endproperty
    property p_start_pulse; @(posedge ref_clk) disable iff (!rst_n) adc_start |=> !adc_start; endproperty
    property p_start_running; @(posedge ref_clk) disable iff (!rst_n) adc_start |-> loop_running; endproperty
    property p_stop_quiet; @(posedge ref_clk) disable iff (!rst_n) $fell(loop_running) |-> !adc_start [*8]; endproperty
    property p_chan_order;
        @(posedge ref_clk) disable iff (!rst_n) adc_start |-> adc_chan == 3'(last_chan + 3'h1)
            || adc_chan == 3'h0 || (adc_chan == 3'h7 && last_chan == 3'h7);
    endproperty
    property p_chan_stable; @(posedge ref_clk) disable iff (!rst_n) !adc_start |-> $stable(adc_chan); endproperty
    property p_event_pulse; @(posedge ref_clk) disable iff (!rst_n) limit_event |=> !limit_event; endproperty
    a_busy_after_take: assert property (p_busy_after_take) else $error("busy not raised after take");
    a_ack_bound: assert property (p_ack_bound) else $error("no ack within 40 link cycles");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
    a_start_running: assert property (p_start_running) else $error("start while stopped");
    a_stop_quiet: assert property (p_stop_quiet) else $error("start after stop");
    a_chan_order: assert property (p_chan_order) else $error("channel out of order");
    a_chan_stable: assert property (p_chan_stable) else $error("channel moved between starts");
    a_event_pulse: assert property (p_event_pulse) else $error("event longer than one cycle");
endmodule : mlm_monitor_props
`default_nettype wire

// [mlm_adc_model.sv]
// converter model: answers each start after a set latency, remote samples wobble around the base
`timescale 1ns/1ps
`default_nettype none
module mlm_adc_model (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // converter port
    input wire logic        adc_start,
    input wire logic [2:0]  adc_chan,
    output logic            adc_done,
    output logic [7:0]      adc_data,
    // settings from the bench
    input wire logic [63:0] chan_vals,
    input wire logic [3:0]  lat
);
    logic [3:0] cnt;
    logic [3:0] k;
    logic [7:0] delta;
    // offsets sum to -1 over 16 samples, so a truncating average shows base - 1
    assign delta = (k == 4'hF) ? 8'hFA : (k[0] ? 8'hFB : 8'h05);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            k <= 4'h0;
            adc_done <= 1'b0;
            adc_data <= 8'h5A;
        end else begin
            adc_done <= 1'b0;
            if (adc_start) cnt <= lat;
            else if (cnt != 4'h0) cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                adc_done <= 1'b1;
                adc_data <= chan_vals[{adc_chan, 3'b000} +: 8] + ((adc_chan == 3'h7) ? delta : 8'h00);
                k <= (adc_chan == 3'h7) ? k + 4'h1 : 4'h0;
            end else adc_data <= ~adc_data; // data is not held outside the done cycle
        end
    end
endmodule : mlm_adc_model
`default_nettype wire

// [mlm_monitor_tb.sv]
// self-checking bench: link accesses, converter model, slot timing and scoreboard
`timescale 1ns/1ps
`default_nettype none
module mlm_monitor_tb;
    localparam int SLOT = 40;
    localparam int REM  = 120;
    logic        ref_clk = 1'b0, link_clk = 1'b0, link_en = 1'b1, rst_n = 1'b0;
    logic        link_req = 1'b0, link_we = 1'b0, link_ack, link_busy, adc_start, adc_done;
    logic [7:0]  link_addr = 8'h00, link_wdata = 8'h00, link_rdata, adc_data;
    logic [2:0]  adc_chan, pch = 3'h7;
    logic        limit_event, loop_running;
    logic [3:0]  faults = 4'h0, lat = 4'h1;
    logic [63:0] chan_vals = 64'h0;
    logic [8:0]  sb[$];
    int          n_fail = 0, n_tests = 0, cyc = 0, t0 = -1, n_ev = 0;
    always #25 ref_clk = ~ref_clk;
    // the host link clock stands still while wt waits
    always begin
        #62.5;
        link_clk = link_en ? ~link_clk : 1'b0;
    end
    mlm_monitor #(.SLOT_CYCLES(SLOT), .REMOTE_CYCLES(REM)) i_mlm_monitor (.ref_clk(ref_clk), .link_clk(link_clk),
        .rst_n(rst_n), .link_req(link_req), .link_we(link_we), .link_addr(link_addr), .link_wdata(link_wdata),
        .link_rdata(link_rdata), .link_ack(link_ack), .link_busy(link_busy), .adc_start(adc_start),
        .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data), .anode_gnd_short(faults[0]),
        .anode_supply_short(faults[1]), .diode_short(faults[2]), .diode_open(faults[3]),
        .limit_event(limit_event), .loop_running(loop_running));
    mlm_adc_model i_mlm_adc_model (.ref_clk(ref_clk), .rst_n(rst_n), .adc_start(adc_start), .adc_chan(adc_chan),
        .adc_done(adc_done), .adc_data(adc_data), .chan_vals(chan_vals), .lat(lat));
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic wt(input int n);
        link_en = 1'b0;
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : wt
    // request held until the edge that shows ack, then released to inverted lines
    task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
        link_en = 1'b1;
        @(posedge link_clk);
        #2;
        link_req = 1'b1; link_we = we; link_addr = a; link_wdata = d;
        sb.push_back(e);
        do begin @(posedge link_clk); #1; end while (link_ack !== 1'b1);
        #1;
        link_req = 1'b0; link_addr = ~a; link_wdata = ~d;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d); acc(1'b1, a, d, 9'h000); endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e); acc(1'b0, a, 8'h00, {1'b1, e}); endtask : rd
    always @(posedge link_clk) begin
        #1;
        if (link_ack === 1'b1 && sb.size() > 0) begin
            if (sb[0][8]) chk(sb[0][7:0], link_rdata);
            void'(sb.pop_front());
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin n_fail++; stop_test(); end
    end
    always @(posedge ref_clk) begin
        #1;
        if (limit_event === 1'b1) n_ev++;
        if (loop_running !== 1'b1) begin t0 = -1; pch = 3'h7; end
        else if (adc_start === 1'b1 && adc_chan !== pch) begin
            if (t0 >= 0) chk(8'((pch == 3'h7) ? REM : SLOT), 8'(cyc - t0));
            t0 = cyc;
            pch = adc_chan;
        end
    end
    initial begin
        logic [7:0] hi[8], lo[8], ex[8], st;
        int c;
        void'($urandom(32'hA6D0));
        repeat (2) @(posedge link_clk);
        #2 rst_n = 1'b1;
        rd(8'h40, 8'h00); rd(8'h41, 8'h00); rd(8'h42, 8'h00); rd(8'h27, 8'h00); rd(8'h50, 8'h00);
        wr(8'h41, 8'hFF); rd(8'h41, 8'h00);
        $display("test reset values done");
        for (c = 0; c < 8; c++) begin
            hi[c] = 8'($urandom); lo[c] = 8'($urandom);
            wr(8'h30 + 8'(2 * c), hi[c]); wr(8'h31 + 8'(2 * c), lo[c]);
        end
        rd(8'h3F, lo[7]);
        chan_vals = {$urandom, $urandom};
        chan_vals[55:48] = 8'h80;
        chan_vals[63:56] = 8'($urandom_range(200)) - 8'h64;
        lat = 4'($urandom_range(3, 1));
        for (c = 0; c < 8; c++) begin
            ex[c] = chan_vals[8 * c +: 8] - ((c == 7) ? 8'h01 : 8'h00);
            st[c] = (c > 5) ? ($signed(ex[c]) > $signed(hi[c]) || $signed(ex[c]) < $signed(lo[c]))
                            : (ex[c] > hi[c] || ex[c] < lo[c]);
        end
        wr(8'h40, 8'h01); wt(900);
        for (c = 0; c < 8; c++) rd(8'h20 + 8'(c), ex[c]);
        rd(8'h41, st); rd(8'h41, st); rd(8'h42, 8'h00);
        chk(8'(st != 8'h00), 8'(n_ev != 0));
        $display("test monitor loop done");
        for (c = 0; c < 4; c++) begin
            faults = 4'h1 << c; wt(900); rd(8'h42, 8'h40);
            faults = 4'h0; wt(900); rd(8'h42, 8'h00);
        end
        $display("test diode faults done");
        wr(8'h40, 8'h00); wt(3); chk(8'h00, {7'h0, loop_running});
        chan_vals = ~chan_vals; wt(500); rd(8'h20, ex[0]); rd(8'h41, st);
        $display("test stop done");
        stop_test();
    end
endmodule : mlm_monitor_tb
bind mlm_monitor mlm_monitor_props i_mlm_monitor_props (.ref_clk(ref_clk), .link_clk(link_clk), .rst_n(rst_n),
    .link_req(link_req), .link_ack(link_ack), .link_busy(link_busy), .adc_start(adc_start),
    .adc_chan(adc_chan), .limit_event(limit_event), .loop_running(loop_running));
`default_nettype wire
